// ==== verilog/cpe_pkg.sv ====
`default_nettype none
// ==========================================================================
// Shared constants of the current and power calculation engine.
// ==========================================================================
package cpe_pkg;

  // ========================================================================
  // Register pointers, three bits wide, as carried in the pointer byte.
  // ========================================================================
  localparam logic [2:0] REG_OPERATING_SETTINGS = 3'h0;
  localparam logic [2:0] REG_SENSE_DROP_RESULT = 3'h1;
  localparam logic [2:0] REG_RAIL_VOLTAGE_RESULT = 3'h2;
  localparam logic [2:0] REG_POWER_RESULT = 3'h3;
  localparam logic [2:0] REG_CURRENT_RESULT = 3'h4;
  localparam logic [2:0] REG_SCALING_WORD = 3'h5;
  localparam int PTR_WIDTH = 3;

  // ========================================================================
  // Reset values and field positions.
  // ========================================================================
  localparam logic [15:0] SETTINGS_RESET = 16'h4127;
  localparam logic [15:0] SCALING_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int SETTINGS_SOFT_RESET_BIT = 15;
  localparam int RAIL_SIGN_BIT = 15;

  // ========================================================================
  // Arithmetic constants of the two result equations.
  // ========================================================================
  localparam logic signed [33:0] CURRENT_DIVISOR = 34'sh800;
  localparam logic signed [33:0] POWER_DIVISOR = 34'sh4e20;
  localparam int POWER_TO_CURRENT_STEP_RATIO = 25;
  localparam real SCALING_NUMERATOR = 0.00512;
  localparam real RAIL_STEP_MV = 1.25;

  // ========================================================================
  // Serial link framing.
  // ========================================================================
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SEEN_MARK = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXACK
  } cpe_state_t;

endpackage
`default_nettype wire

// ==== verilog/cpe_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpe_engine
  import cpe_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary serial address of this device.
) (
  input wire logic clk, // 100 MHz system clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic scl_in, // Serial clock pin level.
  input wire logic sda_in, // Serial data pin level.
  output logic sda_out, // Serial data drive value, always low.
  output logic sda_oe_n, // Low while the device pulls data low.
  input wire logic sample_valid, // One-cycle strobe of a fresh converter pair.
  input wire logic [15:0] sense_drop_sample, // Signed sense drop conversion.
  input wire logic [15:0] rail_sample // Rail voltage conversion.
);

  // ========================================================================
  // Elaboration check.
  // ========================================================================
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_addr_check
    $error("DEV_ADDR falls in a reserved serial address range.");
  end
  // Signed division that truncates toward zero and keeps the low word.
  function automatic logic [15:0] div_trunc(input logic signed [33:0] prod,
                                            input logic signed [33:0] divisor);
    logic signed [33:0] quo;
    quo = prod / divisor;
    return quo[15:0];
  endfunction

  // ========================================================================
  // Pin synchronisers.
  // ========================================================================
  logic [2:0] scl_sync_r, scl_sync_nxt, sda_sync_r, sda_sync_nxt;
  logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
  logic scl_prev_r, scl_prev_nxt, sda_prev_r, sda_prev_nxt;

  // A level is accepted only once the second and third stages agree, which
  // swallows single-cycle glitches on the slow pins.
  always_comb begin
    scl_sync_nxt = {scl_sync_r[1:0], scl_in};
    sda_sync_nxt = {sda_sync_r[1:0], sda_in};
    scl_f_nxt = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
    sda_f_nxt = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;
    scl_prev_nxt = scl_f_r;
    sda_prev_nxt = sda_f_r;
  end

  // Idle bus is high on both lines, so reset to that level.
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sync_r <= scl_sync_nxt;
      sda_sync_r <= sda_sync_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
      scl_prev_r <= scl_prev_nxt;
      sda_prev_r <= sda_prev_nxt;
    end
  end

  logic bus_start, bus_stop, scl_rise, scl_fall;
  // Framing events derived from the filtered levels only.
  assign bus_start = scl_f_r & sda_prev_r & ~sda_f_r;
  assign bus_stop = scl_f_r & ~sda_prev_r & sda_f_r;
  assign scl_rise = scl_f_r & ~scl_prev_r;
  assign scl_fall = ~scl_f_r & scl_prev_r;

  // ========================================================================
  // Result arithmetic.
  // ========================================================================
  logic [15:0] sense_drop_r, sense_drop_nxt, rail_voltage_r, rail_voltage_nxt;
  logic [15:0] current_r, current_nxt, power_r, power_nxt;
  logic cur_pend_r, cur_pend_nxt, pow_pend_r, pow_pend_nxt;
  logic [15:0] operating_settings_r, operating_settings_nxt, scaling_word_r, scaling_word_nxt;
  logic soft_rst_r, soft_rst_nxt;

  // Two-stage pipeline: current one cycle after capture, power the next, so
  // power uses the current computed from the same sample unless strobes arrive on back-to-back cycles.
  always_comb begin
    sense_drop_nxt = sense_drop_r;
    rail_voltage_nxt = rail_voltage_r;
    current_nxt = current_r;
    power_nxt = power_r;
    cur_pend_nxt = 1'b0;
    pow_pend_nxt = 1'b0;
    if (soft_rst_r) begin
      sense_drop_nxt = RESULT_RESET;
      rail_voltage_nxt = RESULT_RESET;
      current_nxt = RESULT_RESET;
      power_nxt = RESULT_RESET;
    end else begin
      if (sample_valid) begin
        sense_drop_nxt = sense_drop_sample;
        rail_voltage_nxt = rail_sample;
        rail_voltage_nxt[RAIL_SIGN_BIT] = 1'b0;
        cur_pend_nxt = 1'b1;
      end
      if (cur_pend_r) begin
        current_nxt = div_trunc(34'($signed(sense_drop_r) * $signed({1'b0, scaling_word_r})),
                                CURRENT_DIVISOR);
        pow_pend_nxt = 1'b1;
      end
      if (pow_pend_r) begin
        // The fixed divisor sets the power step at 25 current steps.
        power_nxt = div_trunc(34'($signed(current_r) * $signed({1'b0, rail_voltage_r})),
                              POWER_DIVISOR);
      end
      if (scaling_word_r == SCALING_RESET) begin
        current_nxt = RESULT_RESET;
        power_nxt = RESULT_RESET;
      end
    end
  end

  // Result registers and the pipeline markers.
  always_ff @(posedge clk) begin
    if (reset) begin
      sense_drop_r <= RESULT_RESET;
      rail_voltage_r <= RESULT_RESET;
      current_r <= RESULT_RESET;
      power_r <= RESULT_RESET;
      cur_pend_r <= 1'b0;
      pow_pend_r <= 1'b0;
    end else begin
      sense_drop_r <= sense_drop_nxt;
      rail_voltage_r <= rail_voltage_nxt;
      current_r <= current_nxt;
      power_r <= power_nxt;
      cur_pend_r <= cur_pend_nxt;
      pow_pend_r <= pow_pend_nxt;
    end
  end

  // Register read multiplexer; unmapped pointers read zero.
  function automatic logic [15:0] read_reg(input logic [PTR_WIDTH-1:0] ptr);
    case (ptr)
      REG_OPERATING_SETTINGS: return operating_settings_r;
      REG_SENSE_DROP_RESULT: return sense_drop_r;
      REG_RAIL_VOLTAGE_RESULT: return rail_voltage_r;
      REG_POWER_RESULT: return power_r;
      REG_CURRENT_RESULT: return current_r;
      REG_SCALING_WORD: return scaling_word_r;
      default: return 16'h0000;
    endcase
  endfunction

  // ========================================================================
  // Serial register port.
  // ========================================================================
  cpe_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt, hold_r, hold_nxt;
  logic [15:0] tx_word_r, tx_word_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_idx_r, byte_idx_nxt;
  logic [PTR_WIDTH-1:0] ptr_r, ptr_nxt;
  logic rd_r, rd_nxt, tx_lo_r, tx_lo_nxt, oe_n_r, oe_n_nxt;

  // Byte engine. Data is sampled on clock rise and driven after clock fall;
  // the filter delay keeps our data change well after the host's fall.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    hold_nxt = hold_r;
    tx_word_nxt = tx_word_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_idx_nxt = byte_idx_r;
    ptr_nxt = ptr_r;
    rd_nxt = rd_r;
    tx_lo_nxt = tx_lo_r;
    oe_n_nxt = oe_n_r;
    operating_settings_nxt = operating_settings_r;
    scaling_word_nxt = scaling_word_r;
    soft_rst_nxt = 1'b0;
    if (bus_start) begin
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      byte_idx_nxt = 2'h0;
      oe_n_nxt = 1'b1;
    end else if (bus_stop) begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_f_r};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            state_nxt = ST_ACK;
            oe_n_nxt = 1'b0;
            if (state_r == ST_ADDR) begin
              rd_nxt = shift_r[0];
              if (shift_r[7:1] != DEV_ADDR) begin
                state_nxt = ST_IDLE;
                oe_n_nxt = 1'b1;
              end
            end else begin
              // Pointer first, then high and low bytes of each word.
              byte_idx_nxt = (byte_idx_r == 2'h2) ? 2'h1 : byte_idx_r + 2'h1;
              case (byte_idx_r)
                2'h0: ptr_nxt = shift_r[PTR_WIDTH-1:0];
                2'h1: hold_nxt = shift_r;
                default: begin
                  if (ptr_r == REG_OPERATING_SETTINGS) begin
                    if (hold_r[SETTINGS_SOFT_RESET_BIT-8]) begin
                      operating_settings_nxt = SETTINGS_RESET;
                      scaling_word_nxt = SCALING_RESET;
                      soft_rst_nxt = 1'b1;
                    end else begin
                      operating_settings_nxt = {hold_r, shift_r};
                    end
                  end else if (ptr_r == REG_SCALING_WORD) begin
                    scaling_word_nxt = {hold_r, shift_r};
                  end
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
            state_nxt = ST_RX;
            if (rd_r) begin
              tx_word_nxt = read_reg(ptr_r);
              shift_nxt = tx_word_nxt[15:8];
              tx_lo_nxt = 1'b1;
              oe_n_nxt = shift_nxt[7];
              state_nxt = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              oe_n_nxt = 1'b1;
              state_nxt = ST_TXACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_n_nxt = shift_r[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            // A not-acknowledge ends the read; wait for stop or start.
            state_nxt = sda_f_r ? ST_IDLE : ST_TXACK;
            bit_cnt_nxt = ACK_SEEN_MARK;
          end else if (scl_fall && bit_cnt_r == ACK_SEEN_MARK) begin
            if (tx_lo_r) begin
              shift_nxt = tx_word_r[7:0];
              tx_lo_nxt = 1'b0;
            end else begin
              tx_word_nxt = read_reg(ptr_r);
              shift_nxt = tx_word_nxt[15:8];
              tx_lo_nxt = 1'b1;
            end
            oe_n_nxt = shift_nxt[7];
            bit_cnt_nxt = 4'h0;
            state_nxt = ST_TX;
          end
        end
        default: begin
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  // The pointer survives a stop so a later read can reuse it.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      hold_r <= 8'h00;
      tx_word_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      ptr_r <= REG_OPERATING_SETTINGS;
      rd_r <= 1'b0;
      tx_lo_r <= 1'b0;
      oe_n_r <= 1'b1;
      operating_settings_r <= SETTINGS_RESET;
      scaling_word_r <= SCALING_RESET;
      soft_rst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      hold_r <= hold_nxt;
      tx_word_r <= tx_word_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      ptr_r <= ptr_nxt;
      rd_r <= rd_nxt;
      tx_lo_r <= tx_lo_nxt;
      oe_n_r <= oe_n_nxt;
      operating_settings_r <= operating_settings_nxt;
      scaling_word_r <= scaling_word_nxt;
      soft_rst_r <= soft_rst_nxt;
    end
  end

  // Open-drain pin: the data value is a constant low held in a flop.
  logic sda_out_r;
  always_ff @(posedge clk) begin
    sda_out_r <= 1'b0;
  end
  assign sda_out = sda_out_r;
  assign sda_oe_n = oe_n_r;

endmodule
`default_nettype wire

// ==== tb/cpe_engine_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker of the serial target.
// ==========================================================================
module cpe_engine_props (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic scl_in, // Serial clock pin.
  input wire logic sda_in, // Resolved data wire.
  input wire logic sda_out, // Device drive value.
  input wire logic sda_oe_n // Device pull enable, active low.
);
  logic [7:0] low_run_r;
  logic [7:0] low_run_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A pull that never ends would hang the whole bus, so its length is counted.
  always_comb begin
    low_run_nxt = sda_oe_n ? 8'h00 : low_run_r + 8'h01;
  end

  // Run length register.
  always_ff @(posedge clk) begin
    low_run_r <= reset ? 8'h00 : low_run_nxt;
  end

  sequence scl_low_settled;
    !scl_in && !$past(scl_in, 2);
  endsequence

  sequence stop_edge;
    scl_in && $rose(sda_in);
  endsequence

  chk_drive_zero: assert property (sda_out == 1'b0)
    else $error("data drive value is not low");
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> sda_oe_n)
    else $error("data pulled during reset");
  chk_boot_quiet: assert property ($fell(reset) |-> sda_oe_n [*8])
    else $error("data pulled right after reset");
  chk_pull_late: assert property ($fell(sda_oe_n) |-> scl_low_settled)
    else $error("pull started outside a settled clock low");
  chk_release_late: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("release while clock high");
  chk_stable_high: assert property ($rose(scl_in) |=> $stable(sda_oe_n) [*6])
    else $error("data changed while clock high");
  chk_stop_quiet: assert property (stop_edge |-> sda_oe_n [*8])
    else $error("data pulled after a stop");
  chk_low_bounded: assert property (low_run_r < 8'hc8)
    else $error("data pulled low too long");
endmodule
bind cpe_engine cpe_engine_props chk_u (.clk(clk), .reset(reset), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
`default_nettype wire

// ==== tb/cpe_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Serial bus host that reads and writes the engine's registers.
// ==========================================================================
module cpe_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary target address.
) (
  input wire logic clk, // Paces the serial clock.
  input wire logic sda, // Resolved data wire.
  output logic scl, // Serial clock.
  output logic sda_drv, // Host drive, 0 pulls low.
  output logic [15:0] rd_word, // Last word read.
  output logic rd_valid, // One-cycle pulse with a fresh word.
  output logic [7:0] nack_cnt // Missing target acknowledges.
);
  localparam int HALF = 8;

  // Idle bus at time zero.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_word = 16'h0000;
    rd_valid = 1'b0;
    nack_cnt = 8'h00;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data moves two cycles after the clock fell so it never races the edge.
  task automatic bit_io(input logic b, output logic s);
    wait_n(2);
    sda_drv = b;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    s = sda;
    scl = 1'b0;
  endtask

  task automatic start_c();
    wait_n(2);
    sda_drv = 1'b1;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    sda_drv = 1'b0;
    wait_n(HALF);
    scl = 1'b0;
  endtask

  task automatic stop_c();
    wait_n(2);
    sda_drv = 1'b0;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    sda_drv = 1'b1;
    wait_n(HALF);
  endtask

  // Byte out MSB first, then the acknowledge bit in the other direction.
  // A missing acknowledge counts only where the target owes one, never on
  // the host's own closing not-acknowledge of a read.
  task automatic xfer(input logic [7:0] o, input logic ack_o, input logic tgt,
                      output logic [7:0] i);
    logic a;
    for (int k = 7; k >= 0; k--) begin
      bit_io(o[k], i[k]);
    end
    bit_io(ack_o, a);
    if (tgt && a !== 1'b0) begin
      nack_cnt = nack_cnt + 8'h01;
    end
  endtask

  // High byte first, then low byte, which commits the word.
  task automatic wr_reg(input logic [2:0] ptr, input logic [15:0] v);
    logic [7:0] d;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, d);
    xfer({5'h00, ptr}, 1'b1, 1'b1, d);
    xfer(v[15:8], 1'b1, 1'b1, d);
    xfer(v[7:0], 1'b1, 1'b1, d);
    stop_c();
  endtask

  // Pointer write, repeated start, then two bytes with a closing NACK.
  task automatic rd_reg(input logic [2:0] ptr);
    logic [7:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, d);
    xfer({5'h00, ptr}, 1'b1, 1'b1, d);
    start_c();
    xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b1, d);
    xfer(8'hff, 1'b0, 1'b0, hi);
    xfer(8'hff, 1'b1, 1'b0, lo);
    stop_c();
    rd_word = {hi, lo};
    rd_valid = 1'b1;
    wait_n(1);
    rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/current_power_calc_engine_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the calculation engine.
// ==========================================================================
module current_power_calc_engine_bench;
  import cpe_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a; // Arbitrary address.
  logic clk, reset, scl, host_sda, sda_out, sda_oe_n, sample_valid, rd_valid;
  logic [15:0] sense_drop_sample, rail_sample, rd_word, cal, s, r, c;
  logic [7:0] nack_cnt;
  logic [15:0] exp_q[$];
  int n_mismatch = 0;
  int checked = 0;
  // Open-drain wire with a pull-up.
  wire logic sda = (!sda_oe_n || !host_sda) ? 1'b0 : 1'b1;

  cpe_engine #(.DEV_ADDR(ADDR)) dut_u (.clk(clk), .reset(reset), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
    .sense_drop_sample(sense_drop_sample), .rail_sample(rail_sample));
  cpe_host_model #(.DEV_ADDR(ADDR)) host_u (.clk(clk), .sda(sda), .scl(scl),
    .sda_drv(host_sda), .rd_word(rd_word), .rd_valid(rd_valid), .nack_cnt(nack_cnt));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Signed products divide toward zero, as the engine must.
  function automatic logic [15:0] cur_of(logic [15:0] sv, logic [15:0] cv);
    longint p;
    p = longint'($signed(sv)) * longint'(cv) / 2048;
    return p[15:0];
  endfunction

  function automatic logic [15:0] pwr_of(logic [15:0] cv, logic [15:0] rv);
    longint p;
    p = longint'($signed(cv)) * longint'({1'b0, rv[14:0]}) / 20000;
    return p[15:0];
  endfunction

  task automatic rd_exp(input logic [2:0] ptr, input logic [15:0] v);
    exp_q.push_back(v);
    host_u.rd_reg(ptr);
  endtask

  task automatic samp(input logic [15:0] sv, input logic [15:0] rv);
    @(negedge clk);
    sample_valid = 1'b1;
    sense_drop_sample = sv;
    rail_sample = rv;
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Each finished read takes the oldest expectation off the queue.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check("read word", rd_word, exp_q.pop_front());
    end
  end

  // A clean run takes some 34k cycles; the limit stays well under 100k.
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end

  // Main sequence.
  initial begin
    void'($urandom(39));
    reset = 1'b1;
    sample_valid = 1'b0;
    sense_drop_sample = 16'h0000;
    rail_sample = 16'h0000;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    rd_exp(REG_OPERATING_SETTINGS, 16'h4127);
    rd_exp(REG_SCALING_WORD, 16'h0000);
    samp(16'h1f40, 16'h2570);
    rd_exp(REG_CURRENT_RESULT, 16'h0000);
    rd_exp(REG_POWER_RESULT, 16'h0000);
    rd_exp(REG_SENSE_DROP_RESULT, 16'h1f40);
    host_u.wr_reg(REG_SCALING_WORD, 16'h0a00);
    rd_exp(REG_SCALING_WORD, 16'h0a00);
    samp(16'h1f40, 16'ha570);
    rd_exp(REG_RAIL_VOLTAGE_RESULT, 16'h2570);
    rd_exp(REG_CURRENT_RESULT, 16'h2710);
    rd_exp(REG_POWER_RESULT, 16'h12b8);
    for (int k = 0; k < 6; k++) begin
      cal = 16'($urandom_range(1, 32767));
      s = 16'($urandom);
      r = 16'($urandom);
      host_u.wr_reg(REG_SCALING_WORD, cal);
      samp(16'h0100, 16'h0100);
      samp(s, r);
      c = cur_of(s, cal);
      rd_exp(REG_CURRENT_RESULT, c);
      rd_exp(REG_POWER_RESULT, pwr_of(c, r));
    end
    host_u.wr_reg(REG_CURRENT_RESULT, 16'hbeef);
    rd_exp(REG_CURRENT_RESULT, c);
    rd_exp(3'h6, 16'h0000);
    // Settings are stored as written; bit 15 restores every register.
    host_u.wr_reg(REG_OPERATING_SETTINGS, 16'h4527);
    rd_exp(REG_OPERATING_SETTINGS, 16'h4527);
    host_u.wr_reg(REG_OPERATING_SETTINGS, 16'h8000);
    rd_exp(REG_OPERATING_SETTINGS, 16'h4127);
    rd_exp(REG_SCALING_WORD, 16'h0000);
    rd_exp(REG_SENSE_DROP_RESULT, 16'h0000);
    host_u.wr_reg(REG_SCALING_WORD, 16'h0000);
    samp(16'h1f40, 16'h2570);
    rd_exp(REG_CURRENT_RESULT, 16'h0000);
    rd_exp(REG_POWER_RESULT, 16'h0000);
    repeat (10) @(negedge clk);
    check("acknowledges", {8'h00, nack_cnt}, 16'h0000);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
